// ===== bench/vpa_core_asserts.sv
// Port checker for the video processing amplifier.
// Assumes one clock domain; bound onto vpa_core below.
`timescale 1ns/1ns
`default_nettype none
module vpa_core_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Video stream
	input wire vpa_pkg::vpa_pix_s vid_in,
	input wire vpa_pkg::vpa_pix_s vid_out
);
	// Cycles since reset, saturating
	logic [2:0] age_q;
	// Written and frame-adopted master switch
	logic pen_q;
	logic aen_q;
	// Switch that governs the pixel now entering
	logic eff_en;
	assign eff_en = (vid_in.valid && vid_in.sof) ? pen_q : aen_q;
	// Helper state
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			age_q <= 3'h0;
			pen_q <= 1'b0;
			aen_q <= 1'b0;
		end
		else
		begin
			if (age_q != 3'h7)
				age_q <= age_q + 3'h1;
			if (reg_wr && reg_addr == vpa_pkg::OFS_CTRL)
				pen_q <= reg_wdata[vpa_pkg::CTRL_EN_BIT];
			aen_q <= eff_en;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Confirmed unity request
	sequence s_unity;
		reg_wr && reg_addr == vpa_pkg::OFS_UNITY && reg_wdata == vpa_pkg::UNITY_KEY;
	endsequence
	// Luma gain read
	sequence s_gain_rd;
		reg_rd && reg_addr == vpa_pkg::OFS_LUMA_GAIN;
	endsequence
	// In-range lift write, then its read
	sequence s_lift_wr_rd;
		reg_wr && reg_addr == vpa_pkg::OFS_LUMA_LIFT && $signed(reg_wdata[15:0]) >= -16'sd1000
			&& $signed(reg_wdata[15:0]) <= 16'sd1000 ##1 reg_rd && reg_addr == vpa_pkg::OFS_LUMA_LIFT;
	endsequence
	chk_valid_lat: assert property (age_q[2] |-> vid_out.valid == $past(vid_in.valid, 4))
		else $error("valid latency wrong");
	chk_sof_lat: assert property (age_q[2] |-> vid_out.sof == $past(vid_in.sof, 4))
		else $error("sof latency wrong");
	chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside read cycle");
	chk_unmapped_read: assert property (reg_rd && (reg_addr == vpa_pkg::OFS_UNITY
		|| reg_addr > vpa_pkg::OFS_STATUS) |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	chk_unity_gain: assert property (s_unity ##1 s_gain_rd |=> reg_rdata == 32'h3e8)
		else $error("unity did not restore gain");
	chk_lift_back: assert property (s_lift_wr_rd |=> reg_rdata ==
		{{16{$past(reg_wdata[15], 2)}}, $past(reg_wdata[15:0], 2)})
		else $error("lift read back wrong");
	chk_bypass_pass: assert property (vid_in.valid && !eff_en |-> ##4 vid_out.y == $past(vid_in.y, 4)
		&& vid_out.cb == $past(vid_in.cb, 4) && vid_out.cr == $past(vid_in.cr, 4))
		else $error("bypass altered pixel");
	chk_out_range: assert property (age_q[2] && vid_out.valid && $past(eff_en, 4) |->
		vid_out.y inside {[10'h004:10'h3fb]} && vid_out.cb inside {[10'h004:10'h3fb]})
		else $error("processed pixel out of range");
endmodule // vpa_core_asserts
bind vpa_core vpa_core_asserts u_vpa_core_asserts (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vid_in(vid_in),
	.vid_out(vid_out));
`default_nettype wire

// ===== bench/vpa_core_bench.sv
// Self-checking bench: registers, bypass and processed frames.
// Assumes vpa_src upstream and the bound port checker.
`timescale 1ns/1ns
`default_nettype none
module vpa_core_bench;
	// Expected pixel record
	typedef struct {
		logic byp;
		vpa_pkg::vpa_pix_s px;
		real y;
		real cb;
		real cr;
	} vpa_exp_s;
	// Design ports
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	vpa_pkg::vpa_pix_s vid_in;
	vpa_pkg::vpa_pix_s vid_out;
	// Source control
	logic start = 1'b0;
	logic busy;
	// Score, run length, random state
	int errors = 0;
	int compares = 0;
	int cycles = 0;
	int seed = 32'hb7052d9d;
	// Register model: settings, adopted settings, switches, sof count
	int p [8];
	int ap [8];
	logic pen;
	logic aen;
	logic gang;
	int frames;
	// Ranges and neutral values by offset
	int mn [8] = '{0, -1000, 0, -3600, -68, 500, 500, 500};
	int mx [8] = '{2000, 1000, 2000, 3600, 500, 1091, 1091, 1600};
	int nt [8] = '{1000, 0, 1000, 0, -68, 1091, 1091, 1600};
	// Expectations in flight, oldest last
	vpa_exp_s eh [4];
	always #25 clk = ~clk;
	vpa_core u_vpa_core (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vid_in(vid_in), .vid_out(vid_out));
	vpa_src u_vpa_src (.clk(clk), .sys_rst(sys_rst), .start(start), .len(8'h30), .busy(busy), .vid(vid_in));
	function automatic int clampi(int v, int lo, int hi);
		return v < lo ? lo : (v > hi ? hi : v);
	endfunction
	function automatic real clampr(real v, real lo, real hi);
		return v < lo ? lo : (v > hi ? hi : v);
	endfunction
	// Level in tenths of a percent to luma code
	function automatic real lcode(int s);
		return 64.0 + s * 897.0 / 1024.0;
	endfunction
	// Modelled output of one pixel
	function automatic vpa_exp_s calc(vpa_pkg::vpa_pix_s px, logic en, int s [8]);
		vpa_exp_s e;
		real u;
		real v;
		real a;
		real lim;
		e.byp = !en;
		e.px = px;
		e.y = (px.y - 64.0) * s[0] / 1000.0 + lcode(s[1]);
		if (e.y > lcode(s[6]))
			e.y = lcode(s[6]) + (e.y - lcode(s[6])) / 2.0;
		e.y = clampr(clampr(e.y, lcode(s[4]), lcode(s[5])), 4.0, 1019.0);
		u = (px.cb - 512.0) * s[2] / 1000.0;
		v = (px.cr - 512.0) * s[2] / 1000.0;
		a = s[3] * 3.14159265358979 / 1800.0;
		lim = clampr(s[7] * 459.0 / 1024.0, 0.0, 511.0);
		e.cb = clampr(512.0 + clampr(u * $cos(a) - v * $sin(a), -lim, lim), 4.0, 1019.0);
		e.cr = clampr(512.0 + clampr(u * $sin(a) + v * $cos(a), -lim, lim), 4.0, 1019.0);
		return e;
	endfunction
	// Modelled read data
	function automatic logic [31:0] exp_reg(logic [7:0] a);
		if (a == vpa_pkg::OFS_CTRL)
			return {30'h0, gang, pen};
		if (a == vpa_pkg::OFS_STATUS)
			return {frames[15:0], 14'h0, gang, aen};
		if (a >= 8'h08 && a <= 8'h24 && a[1:0] == 2'b00)
			return 32'(p[(int'(a) - 8) / 4]);
		return 32'h0;
	endfunction
	task automatic chk_eq(logic [31:0] got, logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Match within three codes
	task automatic chk_near(logic [9:0] got, real exp);
		compares++;
		if ((^got) === 1'bx || got - exp > 3.0 || exp - got > 3.0)
		begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, $rtoi(exp));
		end
	endtask
	// One-cycle write; strobe left for the next task to drop
	task automatic wr(logic [7:0] a, logic [31:0] d);
		int i;
		int o;
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		@(posedge clk);
		i = (int'(a) - 8) / 4;
		if (a == vpa_pkg::OFS_CTRL)
		begin
			pen = d[0];
			gang = d[1];
		end
		else if (a == vpa_pkg::OFS_UNITY && d == vpa_pkg::UNITY_KEY)
			p = nt;
		else if (a >= 8'h08 && a <= 8'h24 && a[1:0] == 2'b00)
		begin
			o = p[i];
			p[i] = clampi(int'($signed(d[15:0])), mn[i], mx[i]);
			if (gang && (i == 0 || i == 2))
				p[2 - i] = clampi(p[2 - i] + p[i] - o, 0, 2000);
		end
	endtask
	// Read, data checked in the following cycle
	task automatic rd(logic [7:0] a);
		logic [31:0] e;
		reg_addr <= a;
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		@(posedge clk);
		reg_rd <= 1'b0;
		e = exp_reg(a);
		@(posedge clk);
		chk_eq(reg_rdata, e);
	endtask
	task automatic idle(int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge clk);
	endtask
	// One frame, with a write landing mid-frame
	task automatic frame(logic [7:0] a, logic [31:0] d);
		idle(40);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		repeat (6) @(posedge clk);
		wr(a, d);
		idle(1);
		repeat (400) if (busy) @(posedge clk);
		idle(8);
	endtask
	task automatic do_reset();
		sys_rst <= 1'b1;
		idle(2);
		sys_rst <= 1'b0;
		p = nt;
		pen = 1'b0;
		gang = 1'b0;
	endtask
	task automatic stop_test();
		$display("Compares %0d, errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Pixel monitor: adopts settings at sof, checks output four edges on
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int k = 0; k < 4; k++)
				eh[k].px = '0;
			aen = 1'b0;
			frames = 0;
		end
		else
		begin
			chk_eq({30'h0, vid_out.valid, vid_out.sof}, {30'h0, eh[3].px.valid, eh[3].px.sof});
			if (eh[3].px.valid && eh[3].byp)
				chk_eq(32'(vid_out), 32'(eh[3].px));
			else if (eh[3].px.valid)
			begin
				chk_near(vid_out.y, eh[3].y);
				chk_near(vid_out.cb, eh[3].cb);
				chk_near(vid_out.cr, eh[3].cr);
			end
			for (int k = 3; k > 0; k--)
				eh[k] = eh[k - 1];
			if (vid_in.valid && vid_in.sof)
			begin
				ap = p;
				aen = pen;
				frames++;
			end
			eh[0] = calc(vid_in, aen, ap);
		end
	end
	// Hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 12000)
		begin
			errors++;
			stop_test();
		end
	end
	initial
	begin
		int i;
		int v;
		do_reset();
		for (int a = 0; a < 8'h30; a += 4)
			rd(8'(a));
		frame(vpa_pkg::OFS_LUMA_GAIN, 32'h0);
		wr(vpa_pkg::OFS_LUMA_GAIN, 32'h0000_7fff);
		wr(vpa_pkg::OFS_BLACK_CLIP, 32'hffff_fe00);
		wr(vpa_pkg::OFS_WHITE_CLIP, 32'h0000_01f4);
		wr(vpa_pkg::OFS_CTRL, 32'h1);
		frame(vpa_pkg::OFS_SAT_CLIP, 32'h0000_01f4);
		for (int n = 0; n < 14; n++)
		begin
			wr(vpa_pkg::OFS_CTRL, {30'h0, n[1], n % 5 != 4});
			for (int k = 0; k < 3; k++)
			begin
				i = $unsigned($random(seed)) % 8;
				v = mn[i] - 300 + int'($unsigned($random(seed)) % (mx[i] - mn[i] + 600));
				if (n < 2)
					v = n == 1 ? mx[i] : mn[i];
				wr(8'(8 + 4 * i), {16'($random(seed)), 16'(v)});
				rd(8'(8 + 4 * i));
			end
			frame(8'(8 + 4 * (n % 8)), $random(seed));
		end
		rd(vpa_pkg::OFS_STATUS);
		wr(vpa_pkg::OFS_CTRL, 32'h3);
		wr(vpa_pkg::OFS_LUMA_GAIN, 32'h0000_04b0);
		rd(vpa_pkg::OFS_CHROMA_GAIN);
		wr(vpa_pkg::OFS_CHROMA_GAIN, 32'h0);
		rd(vpa_pkg::OFS_LUMA_GAIN);
		frame(vpa_pkg::OFS_CHROMA_PHASE, 32'h0000_0384);
		wr(vpa_pkg::OFS_UNITY, 32'h0000_5a5b);
		rd(vpa_pkg::OFS_LUMA_GAIN);
		wr(vpa_pkg::OFS_UNITY, vpa_pkg::UNITY_KEY);
		for (int a = 8; a < 8'h28; a += 4)
			rd(8'(a));
		wr(vpa_pkg::OFS_STATUS, $random(seed));
		rd(vpa_pkg::OFS_CTRL);
		frame(vpa_pkg::OFS_STATUS, 32'h0);
		rd(vpa_pkg::OFS_STATUS);
		do_reset();
		for (int a = 0; a < 8'h30; a += 4)
			rd(8'(a));
		stop_test();
	end
endmodule // vpa_core_bench
`default_nettype wire

// ===== bench/vpa_src.sv
// Upstream pixel source: frames of random 4:4:4 pixels.
// Assumes start is a one-cycle pulse while busy is low.
`timescale 1ns/1ns
`default_nettype none
module vpa_src (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Frame request
	input wire logic start,
	input wire logic [7:0] len,
	output logic busy,
	// Pixel stream
	output var vpa_pkg::vpa_pix_s vid
);
	// Valid pixels left in the frame
	int left;
	// Random stream state
	int seed = 32'hb7052d9d;
	// Valid flag of this cycle
	logic v;
	assign busy = left != 0;
	// Pixel generator
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			left <= 0;
			vid <= '0;
		end
		else if (start || left != 0)
		begin
			// First pixel always valid, marks frame start
			v = start || (($random(seed) & 1) != 0);
			vid <= {v, start, 30'($random(seed))};
			left <= start ? int'(len) - 1 : left - int'(v);
		end
		else
			// Idle: data toggles so no stale value lingers
			vid <= {2'b00, ~vid[29:0]};
	end
endmodule // vpa_src
`default_nettype wire

// ===== rtl/vpa_core.sv
// Video processing amplifier: luma gain and lift, chroma gain and hue
// rotation, then soft and hard clipping, with bypass and unity reset.
// Assumes pixels arrive on clk, one per valid cycle, sof on the first pixel.
//
// Operation
// [R01] Master off passes video untouched
// [R02] Master on applies held parameters
// [R03] Confirmed unity reset restores neutral parameters
// [R04] Luma gain 0 to 200 percent
// [R05] Luma lift -100 to 100 percent
// [R06] Chroma gain 0 to 200 percent
// [R07] Chroma phase -360 to 360 degrees
// [R08] Ganged gain moves both gains equally
// [R09] Black hard clip -6.8 to 50 percent
// [R10] White hard clip 50 to 109.1 percent
// [R11] White soft knee 50 to 109.1 percent
// [R12] Chroma saturation clip 50 to 160 percent
// [R13] Adjustments come before all limiting stages
// [R14] New settings adopted only at frame start
`timescale 1ns/1ns
`default_nettype none
module vpa_core (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Video stream
	input wire vpa_pkg::vpa_pix_s vid_in,
	output vpa_pkg::vpa_pix_s vid_out
);
	// One pipeline stage of the pixel path
	typedef struct packed {
		vpa_pkg::vpa_pix_s raw;
		logic en;
		logic signed [15:0] y;
		logic signed [15:0] cb;
		logic signed [15:0] cr;
	} vpa_stage_s;

	// All state of the block
	typedef struct packed {
		vpa_pkg::vpa_param_s prm;
		logic en;
		logic gang;
		vpa_pkg::vpa_coef_s act;
		vpa_pkg::vpa_coef_s act1; // Set seen by stage 2, so a frame start never retimes pixels in flight
		vpa_pkg::vpa_coef_s act2; // Set seen by stage 3
		logic signed [17:0] cx;
		logic signed [17:0] cy;
		logic signed [17:0] cz;
		logic [3:0] citer;
		logic cneg;
		logic signed [15:0] pend_cos;
		logic signed [15:0] pend_sin;
		vpa_pkg::vpa_pix_s p0;
		vpa_stage_s p1;
		vpa_stage_s p2;
		vpa_pkg::vpa_pix_s out;
		logic [15:0] frames;
		logic [31:0] rdata;
	} vpa_state_s;

	vpa_state_s st_q;
	vpa_state_s st_d;

	// Clamp a value into a range
	function automatic logic signed [31:0] clampv(input logic signed [31:0] v, input logic signed [31:0] lo,
		input logic signed [31:0] hi);
		if (v < lo)
			clampv = lo;
		else if (v > hi)
			clampv = hi;
		else
			clampv = v;
	endfunction

	// Sign-extend a setting to 32 bits
	function automatic logic signed [31:0] sx(input logic signed [15:0] v);
		sx = v;
	endfunction

	// Scaled rounding product: (v * m + half) >> sh
	function automatic logic signed [31:0] scale(input logic signed [31:0] v, input logic signed [31:0] m,
		input int sh);
		logic signed [31:0] half;
		half = 32'sd1 <<< (sh - 1);
		scale = (v * m + half) >>> sh;
	endfunction

	// Arctangent of 2^-i in 1/160 degree
	function automatic logic signed [17:0] atan_step(input logic [3:0] i);
		case (i)
			4'd0: atan_step = 18'sd7200;
			4'd1: atan_step = 18'sd4250;
			4'd2: atan_step = 18'sd2246;
			4'd3: atan_step = 18'sd1140;
			4'd4: atan_step = 18'sd572;
			4'd5: atan_step = 18'sd286;
			4'd6: atan_step = 18'sd143;
			4'd7: atan_step = 18'sd72;
			4'd8: atan_step = 18'sd36;
			4'd9: atan_step = 18'sd18;
			4'd10: atan_step = 18'sd9;
			4'd11: atan_step = 18'sd4;
			4'd12: atan_step = 18'sd2;
			default: atan_step = 18'sd1;
		endcase
	endfunction

	// Next-state logic
	always_comb
	begin
		logic signed [31:0] wv;
		logic signed [31:0] delta;
		logic signed [17:0] ang;
		logic signed [31:0] t_y;
		logic signed [31:0] t_cb;
		logic signed [31:0] t_cr;
		logic signed [31:0] lim;
		vpa_pkg::vpa_coef_s nxt;
		wv = {{16{reg_wdata[15]}}, reg_wdata[15:0]};
		delta = 32'sd0;
		ang = 18'sd0;
		t_y = 32'sd0;
		t_cb = 32'sd0;
		t_cr = 32'sd0;
		lim = 32'sd0;
		nxt = '0;
		st_d = st_q;

		// Register writes, each clamped into its legal range
		if (reg_wr)
		begin
			case (reg_addr)
				// Master switch and gang mode
				vpa_pkg::OFS_CTRL:
				begin
					st_d.en = reg_wdata[vpa_pkg::CTRL_EN_BIT];
					st_d.gang = reg_wdata[vpa_pkg::CTRL_GANG_BIT];
				end
				// Unity reset takes effect only with the key
				vpa_pkg::OFS_UNITY:
				begin
					if (reg_wdata == vpa_pkg::UNITY_KEY)
					begin
						st_d.prm.luma_gain = vpa_pkg::GAIN_UNITY; // [R03]
						st_d.prm.lift = vpa_pkg::LIFT_NULL; // [R03]
						st_d.prm.chroma_gain = vpa_pkg::GAIN_UNITY; // [R03]
						st_d.prm.phase = vpa_pkg::PHASE_NULL; // [R03]
						st_d.prm.black = vpa_pkg::BLACK_NULL; // [R03]
						st_d.prm.white = vpa_pkg::WHITE_NULL; // [R03]
						st_d.prm.knee = vpa_pkg::KNEE_NULL; // [R03]
						st_d.prm.sat = vpa_pkg::SAT_NULL; // [R03]
					end
				end
				// Luma gain, dragging chroma gain along when ganged
				vpa_pkg::OFS_LUMA_GAIN:
				begin
					wv = clampv(wv, sx(vpa_pkg::GAIN_MIN), sx(vpa_pkg::GAIN_MAX)); // [R04]
					delta = wv - sx(st_q.prm.luma_gain);
					st_d.prm.luma_gain = wv[15:0];
					if (st_q.gang)
						st_d.prm.chroma_gain = 16'(clampv(sx(st_q.prm.chroma_gain) + delta, sx(vpa_pkg::GAIN_MIN),
							sx(vpa_pkg::GAIN_MAX))); // [R08]
				end
				// Luma lift
				vpa_pkg::OFS_LUMA_LIFT:
					st_d.prm.lift = 16'(clampv(wv, sx(vpa_pkg::LIFT_MIN), sx(vpa_pkg::LIFT_MAX))); // [R05]
				// Chroma gain, dragging luma gain along when ganged
				vpa_pkg::OFS_CHROMA_GAIN:
				begin
					wv = clampv(wv, sx(vpa_pkg::GAIN_MIN), sx(vpa_pkg::GAIN_MAX)); // [R06]
					delta = wv - sx(st_q.prm.chroma_gain);
					st_d.prm.chroma_gain = wv[15:0];
					if (st_q.gang)
						st_d.prm.luma_gain = 16'(clampv(sx(st_q.prm.luma_gain) + delta, sx(vpa_pkg::GAIN_MIN),
							sx(vpa_pkg::GAIN_MAX))); // [R08]
				end
				// Hue rotation
				vpa_pkg::OFS_CHROMA_PHASE:
					st_d.prm.phase = 16'(clampv(wv, sx(vpa_pkg::PHASE_MIN), sx(vpa_pkg::PHASE_MAX))); // [R07]
				// Black floor
				vpa_pkg::OFS_BLACK_CLIP:
					st_d.prm.black = 16'(clampv(wv, sx(vpa_pkg::BLACK_NULL), sx(vpa_pkg::BLACK_MAX))); // [R09]
				// White ceiling
				vpa_pkg::OFS_WHITE_CLIP:
					st_d.prm.white = 16'(clampv(wv, sx(vpa_pkg::WHITE_MIN), sx(vpa_pkg::WHITE_NULL))); // [R10]
				// Soft white knee
				vpa_pkg::OFS_SOFT_KNEE:
					st_d.prm.knee = 16'(clampv(wv, sx(vpa_pkg::WHITE_MIN), sx(vpa_pkg::KNEE_NULL))); // [R11]
				// Chroma saturation limit
				vpa_pkg::OFS_SAT_CLIP:
					st_d.prm.sat = 16'(clampv(wv, sx(vpa_pkg::SAT_MIN), sx(vpa_pkg::SAT_NULL))); // [R12]
				// Other offsets are ignored
				default:
					st_d.prm = st_q.prm;
			endcase
		end

		// Register reads; unmapped offsets read zero
		st_d.rdata = 32'h0000_0000;
		if (reg_rd)
		begin
			case (reg_addr)
				vpa_pkg::OFS_CTRL: st_d.rdata = {30'h0, st_q.gang, st_q.en};
				vpa_pkg::OFS_LUMA_GAIN: st_d.rdata = sx(st_q.prm.luma_gain);
				vpa_pkg::OFS_LUMA_LIFT: st_d.rdata = sx(st_q.prm.lift);
				vpa_pkg::OFS_CHROMA_GAIN: st_d.rdata = sx(st_q.prm.chroma_gain);
				vpa_pkg::OFS_CHROMA_PHASE: st_d.rdata = sx(st_q.prm.phase);
				vpa_pkg::OFS_BLACK_CLIP: st_d.rdata = sx(st_q.prm.black);
				vpa_pkg::OFS_WHITE_CLIP: st_d.rdata = sx(st_q.prm.white);
				vpa_pkg::OFS_SOFT_KNEE: st_d.rdata = sx(st_q.prm.knee);
				vpa_pkg::OFS_SAT_CLIP: st_d.rdata = sx(st_q.prm.sat);
				// Live state: active switch, gang, frame count
				vpa_pkg::OFS_STATUS:
				begin
					st_d.rdata[vpa_pkg::STAT_EN_BIT] = st_q.act.en;
					st_d.rdata[vpa_pkg::STAT_GANG_BIT] = st_q.gang;
					st_d.rdata[vpa_pkg::STAT_FRAMES_LSB +: 16] = st_q.frames;
				end
				default: st_d.rdata = 32'h0000_0000;
			endcase
		end

		// Free-running rotator: turns the held phase into cosine and sine
		if (st_q.citer >= vpa_pkg::CORDIC_STEPS)
		begin
			// Publish the finished pair, then restart from the held phase
			st_d.pend_cos = st_q.cneg ? 16'(-st_q.cx) : st_q.cx[15:0]; // [R07]
			st_d.pend_sin = st_q.cneg ? 16'(-st_q.cy) : st_q.cy[15:0]; // [R07]
			ang = {{2{st_q.prm.phase[15]}}, st_q.prm.phase};
			if (ang > vpa_pkg::HALF_TURN)
				ang = ang - vpa_pkg::FULL_TURN;
			else if (ang < -vpa_pkg::HALF_TURN)
				ang = ang + vpa_pkg::FULL_TURN;
			st_d.cneg = 1'b0;
			// Fold into the right half plane
			if (ang > vpa_pkg::QUARTER_TURN)
			begin
				ang = ang - vpa_pkg::HALF_TURN;
				st_d.cneg = 1'b1;
			end
			else if (ang < -vpa_pkg::QUARTER_TURN)
			begin
				ang = ang + vpa_pkg::HALF_TURN;
				st_d.cneg = 1'b1;
			end
			st_d.cx = vpa_pkg::CORDIC_X0;
			st_d.cy = 18'sd0;
			st_d.cz = ang <<< 4;
			st_d.citer = 4'd0;
		end
		else
		begin
			// One micro-rotation toward zero residual angle
			if (st_q.cz >= 18'sd0)
			begin
				st_d.cx = st_q.cx - (st_q.cy >>> st_q.citer);
				st_d.cy = st_q.cy + (st_q.cx >>> st_q.citer);
				st_d.cz = st_q.cz - atan_step(st_q.citer);
			end
			else
			begin
				st_d.cx = st_q.cx + (st_q.cy >>> st_q.citer);
				st_d.cy = st_q.cy - (st_q.cx >>> st_q.citer);
				st_d.cz = st_q.cz + atan_step(st_q.citer);
			end
			st_d.citer = st_q.citer + 4'd1;
		end

		// Convert held settings into pixel-path coefficients
		nxt.en = st_q.en;
		nxt.yg = 16'(scale(sx(st_q.prm.luma_gain), vpa_pkg::GAIN_MUL, vpa_pkg::GAIN_SHIFT));
		nxt.lift = 16'(scale(sx(st_q.prm.lift), vpa_pkg::YRNG_MUL, vpa_pkg::RNG_SHIFT));
		nxt.cg = 16'(scale(sx(st_q.prm.chroma_gain), vpa_pkg::GAIN_MUL, vpa_pkg::GAIN_SHIFT));
		nxt.cosv = st_q.pend_cos;
		nxt.sinv = st_q.pend_sin;
		nxt.black = 16'(vpa_pkg::Y_BLACK + scale(sx(st_q.prm.black), vpa_pkg::YRNG_MUL, vpa_pkg::RNG_SHIFT));
		nxt.white = 16'(vpa_pkg::Y_BLACK + scale(sx(st_q.prm.white), vpa_pkg::YRNG_MUL, vpa_pkg::RNG_SHIFT));
		nxt.knee = 16'(vpa_pkg::Y_BLACK + scale(sx(st_q.prm.knee), vpa_pkg::YRNG_MUL, vpa_pkg::RNG_SHIFT));
		nxt.sat = 16'(scale(sx(st_q.prm.sat), vpa_pkg::CRNG_MUL, vpa_pkg::RNG_SHIFT));

		// Adopt new coefficients only on the first pixel of a frame
		if (vid_in.valid && vid_in.sof)
		begin
			st_d.act = nxt; // [R14]
			st_d.frames = st_q.frames + 16'd1;
		end

		// Stage 0: capture the incoming pixel
		st_d.p0 = vid_in;

		// Stage 1: luma gain and lift, chroma gain
		st_d.p1.raw = st_q.p0;
		st_d.p1.en = st_q.act.en;
		st_d.act1 = st_q.act; // [R14]
		t_y = scale({22'h000000, st_q.p0.y} - vpa_pkg::Y_BLACK, sx(st_q.act.yg), vpa_pkg::GAIN_SHIFT); // [R04]
		t_y = t_y + vpa_pkg::Y_BLACK + sx(st_q.act.lift); // [R05]
		t_cb = scale({22'h000000, st_q.p0.cb} - vpa_pkg::C_ZERO, sx(st_q.act.cg), vpa_pkg::GAIN_SHIFT); // [R06]
		t_cr = scale({22'h000000, st_q.p0.cr} - vpa_pkg::C_ZERO, sx(st_q.act.cg), vpa_pkg::GAIN_SHIFT); // [R06]
		st_d.p1.y = 16'(clampv(t_y, -32'sd4096, 32'sd4096));
		st_d.p1.cb = 16'(clampv(t_cb, -32'sd4096, 32'sd4096));
		st_d.p1.cr = 16'(clampv(t_cr, -32'sd4096, 32'sd4096));

		// Stage 2: hue rotation, then the soft white knee
		st_d.p2.raw = st_q.p1.raw;
		st_d.p2.en = st_q.p1.en;
		st_d.act2 = st_q.act1; // [R14]
		t_cb = sx(st_q.p1.cb) * sx(st_q.act1.cosv) - sx(st_q.p1.cr) * sx(st_q.act1.sinv);
		t_cr = sx(st_q.p1.cb) * sx(st_q.act1.sinv) + sx(st_q.p1.cr) * sx(st_q.act1.cosv);
		st_d.p2.cb = 16'(scale(t_cb, 32'sd1, vpa_pkg::TRIG_SHIFT)); // [R07]
		st_d.p2.cr = 16'(scale(t_cr, 32'sd1, vpa_pkg::TRIG_SHIFT)); // [R07]
		t_y = sx(st_q.p1.y);
		if (t_y > sx(st_q.act1.knee))
			t_y = sx(st_q.act1.knee) + ((t_y - sx(st_q.act1.knee)) >>> 1); // [R11]
		st_d.p2.y = t_y[15:0];

		// Stage 3: hard limits last, so they bound the final values
		t_y = clampv(sx(st_q.p2.y), sx(st_q.act2.black), sx(st_q.act2.white)); // [R09] [R10] [R13]
		lim = clampv(sx(st_q.act2.sat), 32'sd0, vpa_pkg::C_SWING);
		t_cb = clampv(sx(st_q.p2.cb), -lim, lim) + vpa_pkg::C_ZERO; // [R12] [R13]
		t_cr = clampv(sx(st_q.p2.cr), -lim, lim) + vpa_pkg::C_ZERO; // [R12] [R13]
		t_y = clampv(t_y, vpa_pkg::CODE_MIN, vpa_pkg::CODE_MAX);
		t_cb = clampv(t_cb, vpa_pkg::CODE_MIN, vpa_pkg::CODE_MAX);
		t_cr = clampv(t_cr, vpa_pkg::CODE_MIN, vpa_pkg::CODE_MAX);
		st_d.out = st_q.p2.raw;
		// Processed or untouched pixel, by the switch of its frame
		if (st_q.p2.en)
		begin
			st_d.out.y = t_y[9:0]; // [R02]
			st_d.out.cb = t_cb[9:0]; // [R02]
			st_d.out.cr = t_cr[9:0]; // [R02]
		end
		else
			st_d.out = st_q.p2.raw; // [R01]
	end

	// State register; parameters reset to neutral, switch off
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_q <= '0;
			st_q.prm.luma_gain <= vpa_pkg::GAIN_UNITY;
			st_q.prm.lift <= vpa_pkg::LIFT_NULL;
			st_q.prm.chroma_gain <= vpa_pkg::GAIN_UNITY;
			st_q.prm.phase <= vpa_pkg::PHASE_NULL;
			st_q.prm.black <= vpa_pkg::BLACK_NULL;
			st_q.prm.white <= vpa_pkg::WHITE_NULL;
			st_q.prm.knee <= vpa_pkg::KNEE_NULL;
			st_q.prm.sat <= vpa_pkg::SAT_NULL;
			st_q.citer <= vpa_pkg::CORDIC_STEPS;
		end
		else
			st_q <= st_d;
	end

	// Outputs straight from flip-flops
	assign reg_rdata = st_q.rdata;
	assign vid_out = st_q.out;
endmodule // vpa_core
`default_nettype wire

// ===== shared/vpa_pkg.sv
// Package for the video processing amplifier: register map, neutral values,
// ranges, fixed-point scaling and the pixel and parameter carriers.
// Assumes 10-bit 4:4:4 Y/Cb/Cr video with black at 64 and white at 940.
package vpa_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_UNITY = 8'h04;
	localparam logic [7:0] OFS_LUMA_GAIN = 8'h08;
	localparam logic [7:0] OFS_LUMA_LIFT = 8'h0c;
	localparam logic [7:0] OFS_CHROMA_GAIN = 8'h10;
	localparam logic [7:0] OFS_CHROMA_PHASE = 8'h14;
	localparam logic [7:0] OFS_BLACK_CLIP = 8'h18;
	localparam logic [7:0] OFS_WHITE_CLIP = 8'h1c;
	localparam logic [7:0] OFS_SOFT_KNEE = 8'h20;
	localparam logic [7:0] OFS_SAT_CLIP = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;
	// Control field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_GANG_BIT = 1;
	// Status field positions
	localparam int STAT_EN_BIT = 0;
	localparam int STAT_GANG_BIT = 1;
	localparam int STAT_FRAMES_LSB = 16;
	// Key that confirms a unity reset
	localparam logic [31:0] UNITY_KEY = 32'h0000_5a5a;
	// Neutral values, all in tenths of a percent or of a degree
	localparam logic signed [15:0] GAIN_UNITY = 16'sd1000;
	localparam logic signed [15:0] LIFT_NULL = 16'sd0;
	localparam logic signed [15:0] PHASE_NULL = 16'sd0;
	localparam logic signed [15:0] BLACK_NULL = -16'sd68;
	localparam logic signed [15:0] WHITE_NULL = 16'sd1091;
	localparam logic signed [15:0] KNEE_NULL = 16'sd1091;
	localparam logic signed [15:0] SAT_NULL = 16'sd1600;
	// Setting ranges
	localparam logic signed [15:0] GAIN_MIN = 16'sd0;
	localparam logic signed [15:0] GAIN_MAX = 16'sd2000;
	localparam logic signed [15:0] LIFT_MIN = -16'sd1000;
	localparam logic signed [15:0] LIFT_MAX = 16'sd1000;
	localparam logic signed [15:0] PHASE_MIN = -16'sd3600;
	localparam logic signed [15:0] PHASE_MAX = 16'sd3600;
	localparam logic signed [15:0] BLACK_MAX = 16'sd500;
	localparam logic signed [15:0] WHITE_MIN = 16'sd500;
	localparam logic signed [15:0] SAT_MIN = 16'sd500;
	// Video code levels
	localparam logic signed [31:0] Y_BLACK = 32'sd64;
	localparam logic signed [31:0] C_ZERO = 32'sd512;
	localparam logic signed [31:0] CODE_MIN = 32'sd4;
	localparam logic signed [31:0] CODE_MAX = 32'sd1019;
	localparam logic signed [31:0] C_SWING = 32'sd511;
	// Fixed-point scale factors with shifts
	localparam logic signed [31:0] GAIN_MUL = 32'sd16777;
	localparam int GAIN_SHIFT = 12;
	localparam logic signed [31:0] YRNG_MUL = 32'sd897;
	localparam logic signed [31:0] CRNG_MUL = 32'sd459;
	localparam int RNG_SHIFT = 10;
	localparam int TRIG_SHIFT = 14;
	localparam logic signed [17:0] CORDIC_X0 = 18'sd9949;
	localparam logic [3:0] CORDIC_STEPS = 4'd14;
	localparam logic signed [17:0] HALF_TURN = 18'sd1800;
	localparam logic signed [17:0] QUARTER_TURN = 18'sd900;
	localparam logic signed [17:0] FULL_TURN = 18'sd3600;
	// One pixel of the stream
	typedef struct packed {
		logic valid;
		logic sof;
		logic [9:0] y;
		logic [9:0] cb;
		logic [9:0] cr;
	} vpa_pix_s;
	// Held settings, as software wrote them
	typedef struct packed {
		logic signed [15:0] luma_gain;
		logic signed [15:0] lift;
		logic signed [15:0] chroma_gain;
		logic signed [15:0] phase;
		logic signed [15:0] black;
		logic signed [15:0] white;
		logic signed [15:0] knee;
		logic signed [15:0] sat;
	} vpa_param_s;
	// Settings in the form the pixel path uses
	typedef struct packed {
		logic en;
		logic signed [15:0] yg;
		logic signed [15:0] lift;
		logic signed [15:0] cg;
		logic signed [15:0] cosv;
		logic signed [15:0] sinv;
		logic signed [15:0] black;
		logic signed [15:0] white;
		logic signed [15:0] knee;
		logic signed [15:0] sat;
	} vpa_coef_s;
endpackage
